// ---- design/clock_switch_params.svh ----
// Register offsets, field positions, reset values and timing counts of the clock switch block
`ifndef CLOCK_SWITCH_PARAMS_SVH
`define CLOCK_SWITCH_PARAMS_SVH
// Printed offsets are register indices; the byte address is four times the index
`define IDX_CLOCK_SWITCH_CONTROL 8'h80
`define IDX_SYSTEM_STATE 8'hA1
`define IDX_WAKE_CONFIG 8'hC9
`define IDX_WAKE_DETECT 8'hAF
`define IDX_IRQ_STATUS 8'hB0
`define IDX_IRQ_MASK 8'hB1
`define ADDR_OF(idx) ({2'h0, idx, 2'h0})
// Clock switch control fields
`define CTL_METER_SEL 7
`define CTL_PLL_EN 6
`define CTL_FAST_STOP 5
`define CTL_METER_GATE 4
`define CTL_DISPLAY_GATE 3
`define CTL_SLEEP_HI 2
`define CTL_SLEEP_LO 1
`define CTL_CPU_SEL 0
`define CTL_RESET 8'h00
// System state fields
`define ST_FIRST_LEVEL 5
`define ST_PIN_WAKE 3
`define ST_TIMER_WAKE 2
`define ST_POWER_DOWN 1
`define ST_LINE_POWER 0
// Interrupt status fields
`define IRQ_POWER_DOWN 0
`define IRQ_WAKE 1
`define IRQ_LINE_UP 2
// Time after entering sleep or deep sleep before a wake request is accepted, ns
`define WAKE_SETTLE_NS 40
`define CLK_PERIOD_NS 10
`endif

// ---- design/clock_switch_pkg.sv ----
// Types shared by the clock switch block
package clock_switch_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_SLEEP = 3'h2,
    ST_DEEP = 3'h4
  } power_state_t;
  typedef struct packed {
    logic pin;
    logic rtc;
    logic pulse;
    logic power;
  } wake_src_t;
  typedef struct packed {
    logic por_bor;
    logic ext_pin;
    logic watchdog;
    logic other;
  } reset_cause_t;
  typedef struct packed {
    logic cpu_run;
    logic cpu_from_pll;
    logic meter_run;
    logic meter_from_pll;
    logic display_run;
    logic periph_run;
    logic pll_run;
  } clock_ctl_t;
endpackage

// ---- design/clock_switch_sleep_control.sv ----
// Clock switch, clock gating and sleep control with AXI4-Lite registers
//
// Overview of operation
// R1: Fast-stop write selects oscillator, clears PLL enable and gates the processor clock.
// R2: Fast-stop on battery power enters ordinary sleep, never deep sleep.
// R3: Fast-stop on line power does not enter sleep.
// R4: Metering gate bit stops metering clock; resets to zero, clock running.
// R5: Display gate stops display clock only when PLL feeds processor and metering.
// R6: On battery with oscillator selected, sleep field 11 or 01 enters sleep.
// R7: Sleep field 10 stops processor and peripheral clocks and enters deep sleep.
// R8: Processor select picks oscillator or PLL; reads back current source; resets zero.
// R9: Wake without reset keeps state, clears only sleep, PLL enable, fast-stop bits.
// R10: First-level reset flag set by power-on, pin or watchdog; cleared by others.
// R11: Pin wakeup flag set when a pin event ends sleep or deep sleep.
// R12: Timer/pulse flag set on sleep wakeup; pulse detect bit tells pulse from clock.
// R13: Power-down flag is one below 1.0 V, raises interrupt; zero above 1.1 V.
// R14: Line-power flag is one above 1.1 V and zero below 1.0 V.
// R15: Deep sleep wakes only on pin or power recovery; resets to oscillator state unless wake-without-reset.
// R16: Sleep wakes on pin, clock, pulse or recovery; resets unless wake-without-reset.
// R17: With fast-stop clear, PLL enable starts PLL, feeds processor, locks selection.
// R18: Between thresholds both supply flags hold their previous values.
// R19: Reserved status bits read zero and ignore writes.
`timescale 1ns/1ps
`include "clock_switch_params.svh"

module clock_switch_sleep_control #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_above_high,
  input wire logic supply_below_low,
  input wire clock_switch_pkg::wake_src_t wake_events,
  input wire clock_switch_pkg::reset_cause_t reset_cause,
  input wire logic reset_cause_valid,
  output clock_switch_pkg::clock_ctl_t clock_ctl,
  output clock_switch_pkg::power_state_t power_state,
  output logic wake_reset_req,
  output logic irq
);
  import clock_switch_pkg::*;

  localparam int SETTLE_CYC = (`WAKE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] sync3_reg;
  logic [5:0] pins_raw;
  logic [5:0] pins_stable_reg;
  assign pins_raw = {supply_above_high, supply_below_low, wake_events};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      sync3_reg <= 6'h00;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pins_stable_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          pins_stable_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  logic above_high;
  logic below_low;
  wake_src_t wake_s;
  assign above_high = pins_stable_reg[5];
  assign below_low = pins_stable_reg[4];
  assign wake_s = wake_src_t'(pins_stable_reg[3:0]);

  // ****************************************
  // Bus slave
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic wr_fire;
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_hit_ctl;
  logic wr_hit_wcfg;
  logic wr_hit_irqst;
  logic wr_hit_mask;
  logic wr_mapped;
  assign wr_hit_ctl = awaddr_reg == ADDR_W'(`ADDR_OF(`IDX_CLOCK_SWITCH_CONTROL));
  assign wr_hit_wcfg = awaddr_reg == ADDR_W'(`ADDR_OF(`IDX_WAKE_CONFIG));
  assign wr_hit_irqst = awaddr_reg == ADDR_W'(`ADDR_OF(`IDX_IRQ_STATUS));
  assign wr_hit_mask = awaddr_reg == ADDR_W'(`ADDR_OF(`IDX_IRQ_MASK));
  assign wr_mapped = wr_hit_ctl || wr_hit_wcfg || wr_hit_irqst || wr_hit_mask
    || awaddr_reg == ADDR_W'(`ADDR_OF(`IDX_SYSTEM_STATE))
    || awaddr_reg == ADDR_W'(`ADDR_OF(`IDX_WAKE_DETECT));

  logic bresp_err_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_err_reg <= 1'b0;
    end else if (wr_fire) begin
      bresp_err_reg <= !wr_mapped;
    end
  end
  assign s_axi_bresp = bresp_err_reg ? 2'h2 : 2'h0;

  logic wr_en;
  assign wr_en = wr_fire && wstrb0_reg;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic wake_no_reset_reg;
  logic pulse_detect_reg;
  logic pin_wake_reg;
  logic timer_wake_reg;
  logic first_level_reg;
  logic line_power_reg;
  logic power_down_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic wake_now;
  logic pll_locked_reg;
  power_state_t state_reg;
  power_state_t state_next;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_reg;

  always_comb begin
    ctl_next = ctl_reg;
    if (wr_en && wr_hit_ctl) begin
      ctl_next = wdata_reg;
      if (wdata_reg[`CTL_FAST_STOP]) begin
        ctl_next[`CTL_CPU_SEL] = 1'b0; // R1
        ctl_next[`CTL_PLL_EN] = 1'b0; // R1
      end else if (wdata_reg[`CTL_PLL_EN]) begin
        ctl_next[`CTL_CPU_SEL] = 1'b1; // R17
      end else if (pll_locked_reg) begin
        ctl_next[`CTL_CPU_SEL] = ctl_reg[`CTL_CPU_SEL]; // R17
      end
    end
    if (wake_now && wake_no_reset_reg) begin
      ctl_next[`CTL_PLL_EN] = 1'b0; // R9
      ctl_next[`CTL_FAST_STOP] = 1'b0; // R9
      ctl_next[`CTL_SLEEP_HI] = 1'b0; // R9
      ctl_next[`CTL_SLEEP_LO] = 1'b0; // R9
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= `CTL_RESET; // R4 R8
    end else if (wake_now && !wake_no_reset_reg) begin
      // Cleared at the wake edge itself so a stale sleep field cannot re-enter sleep
      ctl_reg <= `CTL_RESET; // R15 R16
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_locked_reg <= 1'b0;
    end else if (wake_now) begin
      pll_locked_reg <= 1'b0;
    end else if (wr_en && wr_hit_ctl && !wdata_reg[`CTL_FAST_STOP]) begin
      pll_locked_reg <= wdata_reg[`CTL_PLL_EN]; // R17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_no_reset_reg <= 1'b0;
      pulse_detect_reg <= 1'b0;
    end else begin
      if (wr_en && wr_hit_wcfg) begin
        wake_no_reset_reg <= wdata_reg[0];
      end
      if (wake_now && state_reg == ST_SLEEP) begin
        pulse_detect_reg <= wake_s.pulse && !wake_s.rtc; // R12
      end
    end
  end

  // ****************************************
  // Supply monitor flags
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_power_reg <= 1'b0;
      power_down_reg <= 1'b0;
    end else if (above_high) begin
      line_power_reg <= 1'b1; // R14
      power_down_reg <= 1'b0; // R13
    end else if (below_low) begin
      line_power_reg <= 1'b0; // R14
      power_down_reg <= 1'b1; // R13
    end
  end
  // Between thresholds neither branch fires, so both flags hold R18

  // ****************************************
  // Sleep state machine
  // ****************************************
  logic sleep_req;
  logic deep_req;
  logic [1:0] sleep_field;
  logic fast_stop_wr;
  assign sleep_field = {ctl_reg[`CTL_SLEEP_HI], ctl_reg[`CTL_SLEEP_LO]};
  assign fast_stop_wr = wr_en && wr_hit_ctl && wdata_reg[`CTL_FAST_STOP];
  always_comb begin
    sleep_req = 1'b0;
    deep_req = 1'b0;
    if (!line_power_reg && !ctl_reg[`CTL_CPU_SEL]) begin
      sleep_req = sleep_field[0]; // R6
      deep_req = (sleep_field == 2'h2); // R7
    end
    if (fast_stop_wr && !line_power_reg) begin
      sleep_req = 1'b1; // R2
      deep_req = 1'b0; // R2 R3
    end
  end

  always_comb begin
    wake_now = 1'b0;
    case (state_reg)
      ST_SLEEP: wake_now = (settle_reg == '0) && (|wake_s); // R16
      ST_DEEP: wake_now = (settle_reg == '0) && (wake_s.pin || wake_s.power); // R15
      default: wake_now = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (deep_req) begin
          state_next = ST_DEEP;
        end else if (sleep_req) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: if (wake_now) state_next = ST_RUN;
      ST_DEEP: if (wake_now) state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_RUN;
      settle_reg <= '0;
      wake_reset_req <= 1'b0;
    end else begin
      state_reg <= state_next;
      wake_reset_req <= wake_now && !wake_no_reset_reg; // R15 R16
      if (state_reg == ST_RUN && state_next != ST_RUN) begin
        settle_reg <= ($clog2(SETTLE_CYC+1))'(SETTLE_CYC);
      end else if (settle_reg != '0) begin
        settle_reg <= settle_reg - 1'b1;
      end
    end
  end
  assign power_state = state_reg;

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_wake_reg <= 1'b0;
      timer_wake_reg <= 1'b0;
      first_level_reg <= 1'b0;
    end else begin
      if (wake_now) begin
        pin_wake_reg <= wake_s.pin; // R11
        timer_wake_reg <= (state_reg == ST_SLEEP) && (wake_s.rtc || wake_s.pulse); // R12
      end
      if (reset_cause_valid) begin
        first_level_reg <= reset_cause.por_bor || reset_cause.ext_pin
          || reset_cause.watchdog; // R10
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [2:0] irq_events;
  logic line_prev_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev_reg <= 1'b0;
    end else begin
      line_prev_reg <= line_power_reg;
    end
  end
  assign irq_events = {line_power_reg && !line_prev_reg, wake_now,
    below_low && !power_down_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      if (wr_en && wr_hit_mask) begin
        irq_mask_reg <= wdata_reg[2:0];
      end
      if (wr_en && wr_hit_irqst) begin
        irq_status_reg <= (irq_status_reg & ~wdata_reg[2:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events; // R13
      end
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ****************************************
  // Clock outputs
  // ****************************************
  always_comb begin
    clock_ctl.cpu_from_pll = ctl_reg[`CTL_CPU_SEL]; // R8
    clock_ctl.meter_from_pll = ctl_reg[`CTL_METER_SEL];
    clock_ctl.pll_run = ctl_reg[`CTL_PLL_EN] || ctl_reg[`CTL_CPU_SEL]
      || ctl_reg[`CTL_METER_SEL]; // R17
    clock_ctl.cpu_run = state_reg == ST_RUN && !ctl_reg[`CTL_FAST_STOP]; // R1 R6 R7
    clock_ctl.periph_run = state_reg == ST_RUN; // R6 R7
    clock_ctl.meter_run = !ctl_reg[`CTL_METER_GATE] && state_reg != ST_DEEP; // R4
    clock_ctl.display_run = !(ctl_reg[`CTL_DISPLAY_GATE] && ctl_reg[`CTL_CPU_SEL]
      && ctl_reg[`CTL_METER_SEL]); // R5
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [7:0] rd_data;
  logic rd_ok;
  always_comb begin
    rd_data = 8'h00;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ADDR_W'(`ADDR_OF(`IDX_CLOCK_SWITCH_CONTROL)): rd_data = ctl_reg;
      ADDR_W'(`ADDR_OF(`IDX_SYSTEM_STATE)): begin
        rd_data[`ST_FIRST_LEVEL] = first_level_reg;
        rd_data[`ST_PIN_WAKE] = pin_wake_reg;
        rd_data[`ST_TIMER_WAKE] = timer_wake_reg;
        rd_data[`ST_POWER_DOWN] = power_down_reg;
        rd_data[`ST_LINE_POWER] = line_power_reg; // R19
      end
      ADDR_W'(`ADDR_OF(`IDX_WAKE_CONFIG)): rd_data = {7'h00, wake_no_reset_reg};
      ADDR_W'(`ADDR_OF(`IDX_WAKE_DETECT)): rd_data = {4'h0, pulse_detect_reg, 3'h0};
      ADDR_W'(`ADDR_OF(`IDX_IRQ_STATUS)): rd_data = {5'h00, irq_status_reg};
      ADDR_W'(`ADDR_OF(`IDX_IRQ_MASK)): rd_data = {5'h00, irq_mask_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_data};
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- tb/clock_switch_asserts.sv ----
// Concurrent checks on the clock switch block ports
`timescale 1ns/1ps
module clock_switch_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic supply_above_high,
  input wire clock_switch_pkg::wake_src_t wake_events,
  input wire clock_switch_pkg::clock_ctl_t clock_ctl,
  input wire clock_switch_pkg::power_state_t power_state,
  input wire logic wake_reset_req
);
  import clock_switch_pkg::*;
  logic [4:0] since_wake_reg;
  // ***********************************
  // Age of the last pin or power event
  // ***********************************
  always_ff @(posedge aclk) begin
    if (!aresetn || wake_events.pin || wake_events.power) begin
      since_wake_reg <= 5'h00;
    end else if (since_wake_reg != 5'h1F) begin
      since_wake_reg <= since_wake_reg + 5'h01;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence line_held_s;
    supply_above_high [*6];
  endsequence
  sequence deep_exit_s;
    power_state == ST_DEEP ##1 power_state == ST_RUN;
  endsequence
  state_onehot_a: assert property ($onehot(power_state))
    else $error("power state not one-hot");
  sleep_cpu_off_a: assert property (power_state != ST_RUN |-> !clock_ctl.cpu_run)
    else $error("processor clock runs while asleep");
  deep_clocks_off_a: assert property (power_state == ST_DEEP |-> !clock_ctl.periph_run)
    else $error("peripheral clock runs in deep sleep");
  line_no_sleep_a: assert property (line_held_s ##0 power_state == ST_RUN |=>
    power_state == ST_RUN)
    else $error("sleep entered on line power");
  deep_wake_src_a: assert property (deep_exit_s |-> since_wake_reg < 5'h10)
    else $error("deep sleep left without pin or power event");
  wake_pulse_a: assert property (wake_reset_req |->
    power_state == ST_RUN && $past(power_state) != ST_RUN)
    else $error("wake reset request outside a wakeup");
  wake_single_a: assert property (wake_reset_req |=> !wake_reset_req)
    else $error("wake reset request longer than one cycle");
  display_gate_a: assert property (!clock_ctl.display_run |->
    clock_ctl.cpu_from_pll && clock_ctl.meter_from_pll)
    else $error("display clock stopped without both sources on pll");
  fast_stop_a: assert property (power_state == ST_RUN && !clock_ctl.cpu_run |->
    !clock_ctl.cpu_from_pll && !clock_ctl.pll_run)
    else $error("processor gated while pll still selected");
  meter_reset_a: assert property ($rose(aresetn) |-> clock_ctl.meter_run)
    else $error("metering clock stopped after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule

bind clock_switch_sleep_control clock_switch_asserts chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .supply_above_high(supply_above_high), .wake_events(wake_events),
  .clock_ctl(clock_ctl), .power_state(power_state), .wake_reset_req(wake_reset_req));

// ---- tb/tb.sv ----
// Self-checking bench for the clock switch block
`timescale 1ns/1ps
`include "clock_switch_params.svh"
module tb;
  import clock_switch_pkg::*;
  localparam logic [11:0] a_ctl = `ADDR_OF(`IDX_CLOCK_SWITCH_CONTROL);
  localparam logic [11:0] a_st = `ADDR_OF(`IDX_SYSTEM_STATE);
  localparam logic [11:0] a_det = `ADDR_OF(`IDX_WAKE_DETECT);
  localparam logic [11:0] a_cfg = `ADDR_OF(`IDX_WAKE_CONFIG);
  localparam logic [11:0] a_ist = `ADDR_OF(`IDX_IRQ_STATUS);
  localparam logic [11:0] a_msk = `ADDR_OF(`IDX_IRQ_MASK);
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, above, below, rc_valid, wrq, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] m;
  wake_src_t wake;
  reset_cause_t rc;
  clock_ctl_t ck;
  power_state_t ps;
  int failures, total_checks;
  logic [7:0] cv[5] = '{8'h04, 8'h02, 8'h20, 8'h06, 8'h04};
  logic [3:0] wv[5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h1};
  power_state_t es[5] = '{ST_DEEP, ST_SLEEP, ST_SLEEP, ST_SLEEP, ST_DEEP};
  logic [7:0] sv[5] = '{8'h0A, 8'h06, 8'h06, 8'h02, 8'h02};
  clock_switch_sleep_control dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_above_high(above), .supply_below_low(below), .wake_events(wake),
    .reset_cause(rc), .reset_cause_valid(rc_valid), .clock_ctl(ck), .power_state(ps),
    .wake_reset_req(wrq), .irq(irq));
  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 60) begin
      failures++;
      $display("CHECK FAILED at %0t: wait timed out", $time);
      summarize();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((pa || pw) && n < 60) begin
      @(posedge aclk);
      pa = pa && !awready;
      pw = pw && !wready;
      n++;
      awvalid <= pa;
      wvalid <= pw;
    end
    bound(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 60);
    bound(n);
    chk(bresp, er);
  endtask
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 60);
    bound(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 60);
    bound(n);
    rd = rdata;
    rs = rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rdr(a);
    chk(rd, {24'h000000, e});
  endtask
  task automatic wait_ps(input power_state_t s);
    int n;
    n = 0;
    do begin @(negedge aclk); n++; end while (ps !== s && n < 60);
    bound(n);
    @(posedge aclk);
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ***********************************
  // Main sequence
  // ***********************************
  initial begin
    failures = 0;
    total_checks = 0;
    {aresetn, awvalid, wvalid, arvalid, above, below, rc_valid} = 7'h00;
    {awaddr, araddr, wdata, wake, rc} = '0;
    {bready, rready, wstrb} = 6'h3F;
    void'($urandom(32'h32742047));
    tick(8);
    aresetn <= 1'b1;
    tick(1);
    chk(ck, 7'h56);
    chk(ps, ST_RUN);
    rchk(a_ctl, 8'h00);
    rchk(a_st, 8'h00);
    rdr(12'h004);
    chk({rs, rd}, {2'h2, 32'h0});
    wr(12'h004, 8'hFF, 2'h2);
    $display("reset and map test done");
    m = {5'h00, 3'($urandom()) | 3'h1};
    wr(a_msk, m, 2'h0);
    rchk(a_msk, m);
    below <= 1'b1;
    tick(6);
    rchk(a_st, 8'h02);
    rchk(a_ist, 8'h01);
    chk(irq, 1'b1);
    below <= 1'b0;
    tick(6);
    rchk(a_st, 8'h02);
    wr(a_ist, 8'h01, 2'h0);
    chk(irq, 1'b0);
    wr(a_msk, 8'h00, 2'h0);
    above <= 1'b1;
    tick(6);
    rchk(a_st, 8'h01);
    $display("supply flag test done");
    wr(a_ctl, 8'h02, 2'h0);
    tick(6);
    chk(ps, ST_RUN);
    wr(a_ctl, 8'h40, 2'h0);
    chk({ck.cpu_from_pll, ck.pll_run}, 2'h3);
    rdr(a_ctl);
    chk(rd[0], 1'b1);
    wr(a_ctl, 8'hC8, 2'h0);
    chk({ck.display_run, ck.meter_from_pll}, 2'h1);
    wr(a_ctl, 8'h08, 2'h0);
    chk({ck.display_run, ck.cpu_from_pll}, 2'h3);
    wr(a_ctl, 8'h10, 2'h0);
    chk(ck.meter_run, 1'b0);
    wr(a_ctl, 8'h20, 2'h0);
    chk({ck.cpu_run, ck.cpu_from_pll, ck.pll_run}, 3'h0);
    tick(6);
    chk(ps, ST_RUN);
    wr(a_ctl, 8'h00, 2'h0);
    $display("line power clock test done");
    above <= 1'b0;
    below <= 1'b1;
    tick(6);
    cv[1] = ($urandom() & 1) ? 8'h06 : 8'h02;
    for (int i = 0; i < 5; i++) begin
      wr(a_ctl, cv[i], 2'h0);
      tick(2);
      chk(ps, es[i]);
      if (es[i] == ST_DEEP) begin
        wake <= 4'h6;
        tick(8);
        chk(ps, ST_DEEP);
        wake <= 4'h0;
      end
      tick(4);
      wake <= wv[i];
      wait_ps(ST_RUN);
      wake <= 4'h0;
      rchk(a_st, sv[i]);
      rchk(a_ctl, 8'h00);
      rdr(a_det);
      if (sv[i][2]) chk(rd[3], i == 2);
    end
    $display("sleep and wake test done");
    wr(a_cfg, 8'h01, 2'h0);
    wr(a_ctl, 8'h12, 2'h0);
    tick(6);
    chk(ps, ST_SLEEP);
    wake <= 4'h8;
    wait_ps(ST_RUN);
    wake <= 4'h0;
    rchk(a_ctl, 8'h10);
    chk(ck.meter_run, 1'b0);
    $display("wake without reset test done");
    for (int i = 0; i < 4; i++) begin
      rc <= 4'h8 >> i;
      rc_valid <= 1'b1;
      tick(1);
      rc_valid <= 1'b0;
      rdr(a_st);
      chk(rd[5], i < 3);
      chk({rd[7:6], rd[4]}, 3'h0);
    end
    $display("reset cause test done");
    summarize();
  end
endmodule
